// ---- bench/bscce_exec_checker.sv ----
// Assertion checker for the bit-skip, call and clear executor.
`default_nettype none
module bscce_exec_checker
	import bscce_pkg::*;
(
	input  wire logic               i_sys_clk,
	input  wire logic               i_rstn,
	input  wire logic [INSTR_W-1:0] i_instr,
	input  wire logic [PC_W-1:0]    i_instr_pc,
	input  wire logic [DATA_W-1:0]  i_rd_data,
	input  wire logic               o_claim,
	input  wire logic [1:0]         o_phase,
	input  wire logic               o_phase_stb,
	input  wire logic               o_rd_en,
	input  wire logic [FADDR_W-1:0] o_f_addr,
	input  wire logic               o_wr_en,
	input  wire logic [DATA_W-1:0]  o_wr_data,
	input  wire logic               o_z_set,
	input  wire logic               o_stack_push,
	input  wire logic [PC_W-1:0]    o_stack_data,
	input  wire logic               o_pc_load,
	input  wire logic [LIT_W-1:0]   o_pc_low,
	input  wire logic               o_discard,
	input  wire logic               o_nop_cycle
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	logic take;
	assign take = o_phase == PHASE_Q1 && o_phase_stb && !o_nop_cycle;
	sequence s_clr; take && i_instr[13:7] == OPC_CLEAR_FILE_REGISTER; endsequence
	sequence s_skp; take && i_instr[13:10] == OPC_BIT_TEST_SKIP_IF_SET; endsequence
	sequence s_cal; take && i_instr[13:11] == OPC_CALL; endsequence
	sequence s_nop4; o_nop_cycle [*4]; endsequence
	clear_write_a: assert property (
		s_clr |=> o_rd_en ##2 o_wr_en && o_z_set && o_wr_data == CLEAR_VALUE)
		else $error("clear did not read then write zero");
	skip_addr_a: assert property (
		s_skp |=> o_rd_en && o_f_addr == $past(i_instr[6:0])) else $error("skip address wrong");
	skip_taken_a: assert property (
		s_skp ##2 i_rd_data[$past(i_instr[9:7], 2)] |=> o_discard ##1 s_nop4)
		else $error("set bit did not skip");
	skip_kept_a: assert property (
		s_skp ##2 !i_rd_data[$past(i_instr[9:7], 2)] |=> !o_discard ##1 !o_nop_cycle)
		else $error("clear bit skipped");
	call_push_a: assert property (
		s_cal |=> o_stack_push && o_stack_data == $past(i_instr_pc) + PC_INCREMENT)
		else $error("call pushed wrong address");
	call_jump_a: assert property (
		s_cal |=> ##2 o_pc_load && o_discard && o_pc_low == $past(i_instr[10:0], 3))
		else $error("call target wrong");
	call_nop_a: assert property (s_cal |=> ##3 s_nop4)
		else $error("call second cycle missing");
	nop_quiet_a: assert property (
		o_nop_cycle |-> !o_claim && !o_rd_en && !o_stack_push && !o_wr_en)
		else $error("activity in idle cycle");
	phase_step_a: assert property (
		o_phase_stb && $past(i_rstn) |=> o_phase == 2'($past(o_phase) + 2'h1))
		else $error("phase did not advance");
endmodule
bind bscce_exec bscce_exec_checker u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
	.o_claim(o_claim), .o_phase_stb(o_phase_stb), .o_rd_en(o_rd_en), .o_wr_en(o_wr_en),
	.o_z_set(o_z_set), .o_stack_push(o_stack_push), .o_pc_load(o_pc_load),
	.o_discard(o_discard), .o_nop_cycle(o_nop_cycle), .i_instr(i_instr),
	.i_instr_pc(i_instr_pc), .o_stack_data(o_stack_data), .i_rd_data(i_rd_data),
	.o_wr_data(o_wr_data), .o_phase(o_phase), .o_f_addr(o_f_addr), .o_pc_low(o_pc_low));
`default_nettype wire

// ---- bench/test_bit_skip_call_clear_exec.sv ----
// Self-checking bench for the bit-skip, call and clear executor.
`default_nettype none
module test_bit_skip_call_clear_exec
	import bscce_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 0, i_rstn, o_claim, o_phase_stb, o_rd_en, o_wr_en, o_z_set;
	logic o_stack_push, o_pc_load, o_discard, o_nop_cycle;
	logic [1:0] o_phase;
	logic [6:0] o_f_addr;
	logic [7:0] i_rd_data, o_wr_data;
	logic [10:0] o_pc_low;
	logic [12:0] i_instr_pc, o_stack_data;
	logic [13:0] i_instr;
	int bad_count = 0, checks = 0, cyc = 0;
	bscce_exec DUT (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_instr(i_instr),
		.i_instr_pc(i_instr_pc), .i_rd_data(i_rd_data), .o_claim(o_claim), .o_phase(o_phase),
		.o_phase_stb(o_phase_stb), .o_rd_en(o_rd_en), .o_f_addr(o_f_addr), .o_wr_en(o_wr_en),
		.o_wr_data(o_wr_data), .o_z_set(o_z_set), .o_stack_push(o_stack_push),
		.o_stack_data(o_stack_data), .o_pc_load(o_pc_load), .o_pc_low(o_pc_low),
		.o_discard(o_discard), .o_nop_cycle(o_nop_cycle));
	initial forever #12.5 i_sys_clk = ~i_sys_clk;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Words go in at the edge entering Q1 so the next strobe latches them.
	task automatic run(input logic [13:0] w, input logic [12:0] pc, input logic [7:0] rd,
		input logic rde, push, wr, disc);
		do begin @(posedge i_sys_clk); #1; end while (o_phase !== PHASE_Q4);
		@(posedge i_sys_clk);
		i_instr <= w;
		i_instr_pc <= pc;
		i_rd_data <= rd;
		#1 chk(o_claim, 1);
		@(posedge i_sys_clk); #1;
		chk(o_rd_en, rde);
		chk(o_stack_push, push);
		if (push) chk(o_stack_data, 13'(pc + PC_INCREMENT));
		if (rde) chk(o_f_addr, w[6:0]);
		repeat (2) @(posedge i_sys_clk); #1;
		chk({o_wr_en, o_z_set}, {wr, wr});
		if (wr) chk(o_wr_data, CLEAR_VALUE);
		chk({o_discard, o_pc_load}, {disc, push});
		if (push) chk(o_pc_low, w[10:0]);
		// A held call word in the idle cycle must be ignored, not executed again.
		repeat (4) begin
			@(posedge i_sys_clk);
			if (!disc) i_instr <= '0;
			#1 chk({o_nop_cycle, o_claim, o_stack_push}, {disc, 2'b00});
		end
		@(posedge i_sys_clk);
		i_instr <= '0;
	endtask
	task automatic t_clear();
		run(14'h01FF, 13'h0010, 8'h5A, 1, 0, 1, 0);
		run(14'h0180, 13'h0011, 8'hFF, 1, 0, 1, 0);
		$display("clear test done");
	endtask
	task automatic t_skip();
		for (int b = 0; b < 8; b++) begin
			run({4'h7, 3'(b), 7'h55}, 13'h0000, 8'h01 << b, 1, 0, 0, 1);
			run({4'h7, 3'(b), 7'h2A}, 13'h0000, ~(8'h01 << b), 1, 0, 0, 0);
		end
		$display("skip test done");
	endtask
	task automatic t_call();
		run(14'h27FF, 13'h0ABC, 8'h00, 0, 1, 0, 1);
		run(14'h2000, 13'h1FFF, 8'h00, 0, 1, 0, 1);
		$display("call test done");
	endtask
	initial begin
		i_rstn = 0;
		i_instr = '0;
		i_instr_pc = '0;
		i_rd_data = '0;
		repeat (10) @(posedge i_sys_clk);
		i_rstn <= 1;
		t_clear();
		t_skip();
		t_call();
		report_and_stop();
	end
endmodule
`default_nettype wire

// ---- rtl/bscce_exec.sv ----
// Executor for bit-test-skip-if-set, subroutine call and clear-file-register.
//
// Contract
// - Skip test uses 7-bit address, 3-bit bit
// - Set bit: discard next, NOP, two cycles
// - Call loads 11-bit literal into PC<10:0>
// - Call pushes PC+1 before jumping
// - Clear writes zero and sets zero flag
// - Clear: decode, read, process, write; one cycle
`default_nettype none
module bscce_exec
	import bscce_pkg::*;
(
	input  wire logic               i_sys_clk,
	input  wire logic               i_rstn,
	input  wire logic [INSTR_W-1:0] i_instr,
	input  wire logic [PC_W-1:0]    i_instr_pc,
	input  wire logic [DATA_W-1:0]  i_rd_data,
	output logic                    o_claim,
	output logic [1:0]              o_phase,
	output logic                    o_phase_stb,
	output logic                    o_rd_en,
	output logic [FADDR_W-1:0]      o_f_addr,
	output logic                    o_wr_en,
	output logic [DATA_W-1:0]       o_wr_data,
	output logic                    o_z_set,
	output logic                    o_stack_push,
	output logic [PC_W-1:0]         o_stack_data,
	output logic                    o_pc_load,
	output logic [LIT_W-1:0]        o_pc_low,
	output logic                    o_discard,
	output logic                    o_nop_cycle
);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic bscce_op_t bscce_decode(input logic [INSTR_W-1:0] w);
		bscce_op_t op;
		op = BSCCE_OP_NONE;
		if (w[13:10] == OPC_BIT_TEST_SKIP_IF_SET) begin
			op = BSCCE_OP_SKIP_SET;
		end else if (w[13:11] == OPC_CALL) begin
			op = BSCCE_OP_CALL;
		end else if (w[13:7] == OPC_CLEAR_FILE_REGISTER) begin
			op = BSCCE_OP_CLEAR;
		end
		return op;
	endfunction

	// True when the op ends with a throw-away cycle: a call always, a skip
	// only when the tested bit was one.
	function automatic logic bscce_needs_nop(input bscce_op_t op, input logic bit_set);
		return (op == BSCCE_OP_CALL) || (op == BSCCE_OP_SKIP_SET && bit_set);
	endfunction

	typedef struct packed {
		bscce_state_t          state;
		bscce_op_t             op;
		logic [FADDR_W-1:0]    f_addr;
		logic [BIDX_W-1:0]     bit_idx;
		logic [LIT_W-1:0]      lit;
		logic [PC_W-1:0]       ret_addr;
		logic                  bit_val;
		logic [DATA_W-1:0]     wr_data;
	} bscce_exec_st_t;

	bscce_exec_st_t s_q;
	bscce_exec_st_t s_d;

	logic       phase_stb;
	logic [1:0] phase;

	bscce_phase u_phase (
		.i_sys_clk   (i_sys_clk),
		.i_rstn      (i_rstn),
		.o_phase_stb (phase_stb),
		.o_phase     (phase)
	);

	// ------------------------------------------------------------
	// Phase decode
	// ------------------------------------------------------------
	// With one clock per phase the strobe is always high; gating on it keeps
	// the sequencer right should the divider ever be slowed.
	logic in_q1;
	logic in_q2;
	logic in_q3;
	logic in_q4;
	logic exec_cycle;

	assign in_q1      = phase_stb && (phase == PHASE_Q1);
	assign in_q2      = phase_stb && (phase == PHASE_Q2);
	assign in_q3      = phase_stb && (phase == PHASE_Q3);
	assign in_q4      = phase_stb && (phase == PHASE_Q4);
	assign exec_cycle = (s_q.state == BSCCE_ST_EXEC);

	// ------------------------------------------------------------
	// Bit selector
	// ------------------------------------------------------------
	// One match line per bit position; the OR of the masked lines is the
	// tested bit. A flat gate tree keeps the Q3 capture path short even
	// though the index comes from a flop loaded in Q1.
	logic [DATA_W-1:0] bit_hit;

	for (genvar gi = 0; gi < DATA_W; gi++) begin : g_bit_hit
		assign bit_hit[gi] = i_rd_data[gi] && (s_q.bit_idx == BIDX_W'(gi));
	end

	// ------------------------------------------------------------
	// Op in hand
	// ------------------------------------------------------------
	// Every flag is gated by the execute state, so a NOP cycle cannot raise a
	// register, stack or PC strobe even with a stale op left behind.
	logic run_skip;
	logic run_call;
	logic run_clear;
	logic run_nop_end;

	assign run_skip    = exec_cycle && (s_q.op == BSCCE_OP_SKIP_SET);
	assign run_call    = exec_cycle && (s_q.op == BSCCE_OP_CALL);
	assign run_clear   = exec_cycle && (s_q.op == BSCCE_OP_CLEAR);
	assign run_nop_end = exec_cycle && bscce_needs_nop(s_q.op, s_q.bit_val);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// The word offered at Q1 is the one the core fetched in the previous
	// cycle; while a NOP cycle runs it is ignored, which is how the
	// fetched word is thrown away.
	always_comb begin
		s_d = s_q;
		case (s_q.state)
			BSCCE_ST_EXEC: begin
				if (in_q1) begin
					s_d.op       = bscce_decode(i_instr);
					s_d.f_addr   = i_instr[FADDR_LSB +: FADDR_W];
					s_d.bit_idx  = i_instr[BIDX_LSB +: BIDX_W];
					s_d.lit      = i_instr[LIT_LSB +: LIT_W];
					s_d.ret_addr = i_instr_pc + PC_INCREMENT;
				end
				// The bit is caught at the end of Q3, so the Q4 skip decision
				// reads a settled flop rather than the register read bus.
				if (in_q3 && s_q.op == BSCCE_OP_SKIP_SET) begin
					s_d.bit_val = |bit_hit;
				end
				if (in_q3 && s_q.op == BSCCE_OP_CLEAR) begin
					s_d.wr_data = CLEAR_VALUE;
				end
				// The op is dropped at the end of Q4, so a word held through a
				// NOP cycle finds nothing to act on.
				if (in_q4) begin
					if (bscce_needs_nop(s_q.op, s_q.bit_val)) begin
						s_d.state = BSCCE_ST_NOP;
					end
					s_d.op = BSCCE_OP_NONE;
				end
			end
			BSCCE_ST_NOP: begin
				s_d.bit_val = 1'b0;
				if (in_q4) begin
					s_d.state = BSCCE_ST_EXEC;
				end
			end
			default: begin
				s_d.state = BSCCE_ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			// Only state and op matter for behaviour; the rest is cleared so
			// that the data outputs read zero after reset.
			s_q.state    <= BSCCE_ST_EXEC;
			s_q.op       <= BSCCE_OP_NONE;
			s_q.f_addr   <= '0;
			s_q.bit_idx  <= '0;
			s_q.lit      <= '0;
			s_q.ret_addr <= '0;
			s_q.bit_val  <= 1'b0;
			s_q.wr_data  <= CLEAR_VALUE;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Register file side
	// ------------------------------------------------------------
	// Strobes are combinational from the phase so that the core sees them
	// in the phase they belong to; addresses and data come from flops.
	assign o_claim     = exec_cycle && (bscce_decode(i_instr) != BSCCE_OP_NONE);
	assign o_phase     = phase;
	assign o_phase_stb = phase_stb;
	assign o_rd_en     = in_q2 && (run_skip || run_clear);
	assign o_f_addr    = s_q.f_addr;
	assign o_wr_en     = in_q4 && run_clear;
	assign o_z_set     = in_q4 && run_clear;
	assign o_wr_data   = s_q.wr_data;

	// ------------------------------------------------------------
	// Stack and program counter side
	// ------------------------------------------------------------
	// Push in Q2, ahead of the PC write in Q4, so the return address is taken
	// before the jump target overwrites the low PC bits.
	assign o_stack_push = in_q2 && run_call;
	assign o_stack_data = s_q.ret_addr;
	assign o_pc_load    = in_q4 && run_call;
	assign o_pc_low     = s_q.lit;

	// ------------------------------------------------------------
	// Pipeline side
	// ------------------------------------------------------------
	// The upper PC bits and the stack depth live in the core; this block only
	// says when the fetched word must be dropped and the spare cycle runs.
	assign o_discard   = in_q4 && run_nop_end;
	assign o_nop_cycle = !exec_cycle;

endmodule
`default_nettype wire

// ---- rtl/bscce_phase.sv ----
// Phase generator that splits each instruction cycle into four phases.
`default_nettype none
module bscce_phase
	import bscce_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rstn,
	output logic            o_phase_stb,
	output logic [1:0]      o_phase
);

	typedef struct packed {
		logic [PHASE_CNT_W-1:0] div;
		logic [1:0]             phase;
		logic                   stb;
	} bscce_phase_st_t;

	bscce_phase_st_t s_q;
	bscce_phase_st_t s_d;

	localparam logic [PHASE_CNT_W-1:0] DIV_LAST = PHASE_CNT_W'(CLKS_PER_PHASE - 1);

	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	// The strobe marks the last clock of a phase, so every phase
	// holds its value for the whole divider period.
	always_comb begin
		s_d     = s_q;
		s_d.stb = 1'b0;
		if (s_q.div == DIV_LAST) begin
			s_d.div   = '0;
			s_d.phase = s_q.phase + 2'h1;
		end else begin
			s_d.div = s_q.div + PHASE_CNT_W'(1);
		end
		if (s_d.div == DIV_LAST) begin
			s_d.stb = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			s_q.div   <= '0;
			s_q.phase <= PHASE_Q1;
			s_q.stb   <= (DIV_LAST == '0);
		end else begin
			s_q <= s_d;
		end
	end

	assign o_phase_stb = s_q.stb;
	assign o_phase     = s_q.phase;

endmodule
`default_nettype wire

// ---- rtl/bscce_pkg.sv ----
// Shared constants and types of the bit-skip, call and clear executor.
`default_nettype none
package bscce_pkg;

	// ------------------------------------------------------------
	// Instruction word layout
	// ------------------------------------------------------------
	localparam int INSTR_W     = 14;
	localparam int PC_W        = 13;
	localparam int FADDR_W     = 7;
	localparam int BIDX_W      = 3;
	localparam int LIT_W       = 11;
	localparam int DATA_W      = 8;
	localparam int FADDR_LSB   = 0;
	localparam int BIDX_LSB    = 7;
	localparam int LIT_LSB     = 0;

	localparam logic [3:0] OPC_BIT_TEST_SKIP_IF_SET = 4'h7;
	localparam logic [2:0] OPC_CALL                 = 3'h4;
	localparam logic [6:0] OPC_CLEAR_FILE_REGISTER  = 7'h03;

	localparam logic [DATA_W-1:0] CLEAR_VALUE  = 8'h00;
	localparam logic [PC_W-1:0]   PC_INCREMENT = 13'h0001;

	// ------------------------------------------------------------
	// Phase timing
	// ------------------------------------------------------------
	localparam real CLK_PERIOD_NS   = 25.0;
	localparam real PHASE_TIME_NS   = 25.0;
	localparam int  CLKS_PER_PHASE  = (PHASE_TIME_NS / CLK_PERIOD_NS < 1.0) ? 1 :
	                                  int'($floor(PHASE_TIME_NS / CLK_PERIOD_NS));
	localparam int  PHASE_CNT_W     = 4;
	localparam logic [1:0] PHASE_Q1 = 2'h0;
	localparam logic [1:0] PHASE_Q2 = 2'h1;
	localparam logic [1:0] PHASE_Q3 = 2'h2;
	localparam logic [1:0] PHASE_Q4 = 2'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		BSCCE_OP_NONE,
		BSCCE_OP_SKIP_SET,
		BSCCE_OP_CALL,
		BSCCE_OP_CLEAR
	} bscce_op_t;

	typedef enum logic {
		BSCCE_ST_EXEC,
		BSCCE_ST_NOP
	} bscce_state_t;

endpackage
`default_nettype wire
